// file: design/ambient_light_zone_controller.sv
// Ambient light averaging, zone decision, ramp and zone interrupt
`default_nettype none
module ambient_light_zone_controller #(
  parameter int SAMPLE_PERIOD = ambient_zone_pkg::SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register access port
  input wire ambient_zone_pkg::reg_req_t reg_req,
  output var ambient_zone_pkg::reg_resp_t reg_resp,
  // Digitised sensor levels, other domain
  input wire logic [7:0] ambient_input_a,
  input wire logic [7:0] ambient_input_b,
  // Power-save state from device control
  input wire logic power_save,
  // LED side
  output logic [7:0] ambient_level,
  output logic [23:0] group_scale,
  output logic sensing_active,
  // Interrupt pin, active low
  output logic int_n
);
  import ambient_zone_pkg::*;

  if (SAMPLE_PERIOD < 1) begin : g_check
    $error("SAMPLE_PERIOD must be at least one cycle");
  end

  // Host registers
  logic [7:0] ambient_control;
  logic [7:0] ambient_start_select;
  logic [7:0] general_control;
  logic [7:0] zone_threshold [THRESHOLD_COUNT];
  logic [6:0] zone_target [ZONE_COUNT];
  logic zone_change_flag;
  // Datapath state
  logic [2:0] averaging_window_code;
  logic [1:0] input_sel;
  logic [2:0] group_enable;
  logic [7:0] a_s1, a_s2, a_s3, b_s1, b_s2, b_s3;
  logic [7:0] level_a, level_b;
  logic [31:0] tick_count;
  logic sample_tick;
  logic [16:0] acc;
  logic [9:0] sample_count;
  logic [7:0] avg_level;
  logic window_done;
  logic [2:0] zone;
  logic sensing_q;
  logic power_save_q;
  logic start_load;
  logic status_read;

  // Count of thresholds at or below the level gives the zone
  function automatic logic [2:0] zone_of(input logic [7:0] lvl,
                                         input logic [31:0] thr);
    logic [2:0] z;
    z = 3'h0;
    for (int i = 0; i < THRESHOLD_COUNT; i++) begin
      if (lvl >= thr[i*8 +: 8]) begin
        z = z + 3'h1;
      end
    end
    return z;
  endfunction

  // Target with its fixed top bit
  function automatic logic [7:0] target_of(input logic [6:0] data);
    return {1'b1, data};
  endfunction

  assign averaging_window_code = ambient_control[AVG_CODE_LSB +: 3];
  assign input_sel = ambient_control[INPUT_SEL_LSB +: 2];
  assign group_enable = ambient_control[GROUP_ENABLE_LSB +: 3];
  assign status_read = reg_req.read && (reg_req.addr == ADDR_STATUS_FLAGS);
  // Sensing runs while any group asks for it and not in power-save
  logic next_sensing;
  assign next_sensing = (|group_enable) && !power_save;
  // Start zone loads on sensing start or leaving power-save
  assign start_load = next_sensing && (!sensing_q || power_save_q);

  // Register writes; target top bit is not stored, it reads as one
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ambient_control <= RESET_AMBIENT_CONTROL;
      ambient_start_select <= RESET_START_SELECT;
      general_control <= RESET_GENERAL_CONTROL;
      for (int i = 0; i < THRESHOLD_COUNT; i++) begin
        zone_threshold[i] <= RESET_THRESHOLD;
      end
      for (int i = 0; i < ZONE_COUNT; i++) begin
        zone_target[i] <= RESET_TARGET_DATA;
      end
    end else if (reg_req.write) begin
      case (reg_req.addr)
        ADDR_AMBIENT_CONTROL: ambient_control <= reg_req.wdata;
        ADDR_AMBIENT_START_SELECT: ambient_start_select <= reg_req.wdata;
        ADDR_GENERAL_CONTROL: general_control <= reg_req.wdata;
        default: begin
          // Threshold and target blocks, full byte vs seven bits
          for (int i = 0; i < THRESHOLD_COUNT; i++) begin
            if (reg_req.addr == ADDR_ZONE_THRESHOLD_BASE + 8'(i)) begin
              zone_threshold[i] <= reg_req.wdata;
            end
          end
          for (int i = 0; i < ZONE_COUNT; i++) begin
            if (reg_req.addr == ADDR_ZONE_TARGET_BASE + 8'(i)) begin
              zone_target[i] <= reg_req.wdata[6:0];
            end
          end
        end
      endcase
    end
  end

  // Read answer one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_resp <= '0;
    end else begin
      reg_resp.rvalid <= reg_req.read;
      if (reg_req.read) begin
        case (reg_req.addr)
          ADDR_AMBIENT_CONTROL: reg_resp.rdata <= ambient_control;
          ADDR_AMBIENT_START_SELECT: reg_resp.rdata <= ambient_start_select;
          ADDR_GENERAL_CONTROL: reg_resp.rdata <= general_control;
          ADDR_STATUS_FLAGS: reg_resp.rdata <= 8'(zone_change_flag) << ZONE_CHANGE_BIT;
          ADDR_ACTIVE_ZONE_READBACK: reg_resp.rdata <= {5'h00, zone};
          default: begin
            reg_resp.rdata <= 8'h00;
            for (int i = 0; i < THRESHOLD_COUNT; i++) begin
              if (reg_req.addr == ADDR_ZONE_THRESHOLD_BASE + 8'(i)) begin
                reg_resp.rdata <= zone_threshold[i];
              end
            end
            for (int i = 0; i < ZONE_COUNT; i++) begin
              if (reg_req.addr == ADDR_ZONE_TARGET_BASE + 8'(i)) begin
                reg_resp.rdata <= target_of(zone_target[i]);
              end
            end
          end
        endcase
      end
    end
  end

  // Three-stage synchronisers; a word counts once stages two and three agree
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {a_s1, a_s2, a_s3, b_s1, b_s2, b_s3} <= '0;
      level_a <= 8'h00;
      level_b <= 8'h00;
    end else begin
      {a_s1, a_s2, a_s3} <= {ambient_input_a, a_s1, a_s2};
      {b_s1, b_s2, b_s3} <= {ambient_input_b, b_s1, b_s2};
      if (a_s2 == a_s3) begin
        level_a <= a_s3;
      end
      if (b_s2 == b_s3) begin
        level_b <= b_s3;
      end
    end
  end

  // Source selection
  logic [7:0] selected_level;
  always_comb begin
    case (input_sel)
      SEL_LOWER: selected_level = (level_a < level_b) ? level_a : level_b;
      SEL_INPUT_A: selected_level = level_a;
      SEL_INPUT_B: selected_level = level_b;
      SEL_HIGHER: selected_level = (level_a > level_b) ? level_a : level_b;
      default: selected_level = level_a;
    endcase
  end

  // Sample-rate divider, one-cycle enable pulse
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tick_count <= 32'h0;
      sample_tick <= 1'b0;
    end else if (tick_count == 32'(SAMPLE_PERIOD - 1)) begin
      tick_count <= 32'h0;
      sample_tick <= 1'b1;
    end else begin
      tick_count <= tick_count + 32'h1;
      sample_tick <= 1'b0;
    end
  end

  // Window averaging: 4 << code samples, then shift back down
  logic [9:0] window_last;
  logic [16:0] next_acc;
  assign window_last = 10'((MIN_WINDOW_MS << averaging_window_code) - 1);
  assign next_acc = acc + 17'(selected_level);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      acc <= 17'h0;
      sample_count <= 10'h0;
      avg_level <= 8'h00;
      window_done <= 1'b0;
    end else begin
      window_done <= 1'b0;
      if (!next_sensing || start_load) begin
        // Idle or restarting: begin a fresh window
        acc <= 17'h0;
        sample_count <= 10'h0;
      end else if (sample_tick) begin
        if (sample_count >= window_last) begin
          avg_level <= 8'(next_acc >> (MIN_WINDOW_LOG2 + averaging_window_code));
          window_done <= 1'b1;
          acc <= 17'h0;
          sample_count <= 10'h0;
        end else begin
          acc <= next_acc;
          sample_count <= sample_count + 10'h1;
        end
      end
    end
  end

  // Zone tracking, evaluated only at window end
  logic [2:0] next_zone;
  logic zone_changed;
  assign next_zone = zone_of(avg_level, {zone_threshold[3], zone_threshold[2],
                                         zone_threshold[1], zone_threshold[0]});
  assign zone_changed = window_done && (next_zone != zone) && !start_load;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      zone <= 3'h0;
      sensing_q <= 1'b0;
      power_save_q <= 1'b0;
    end else begin
      sensing_q <= next_sensing;
      power_save_q <= power_save;
      if (start_load) begin
        // Codes five and up keep the zone held before
        if (ambient_start_select[START_CODE_LSB +: 3] < START_LAST_MIN) begin
          zone <= ambient_start_select[START_CODE_LSB +: 3];
        end
      end else if (zone_changed) begin
        zone <= next_zone;
      end
    end
  end

  // Ramp one code per sample toward target; start loads of codes 0 to 4 jump directly
  logic [7:0] zone_target_level;
  assign zone_target_level = target_of(zone_target[zone]);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ambient_level <= 8'h80;
    end else if (start_load &&
                 ambient_start_select[START_CODE_LSB +: 3] < START_LAST_MIN) begin
      ambient_level <= target_of(zone_target[ambient_start_select[2:0]]);
    end else if (sample_tick && sensing_q) begin
      if (ambient_level < zone_target_level) begin
        ambient_level <= ambient_level + 8'h01;
      end else if (ambient_level > zone_target_level) begin
        ambient_level <= ambient_level - 8'h01;
      end
    end
  end

  // Per-group scale: enabled groups follow ambient level, others full
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      group_scale <= 24'hffffff;
      sensing_active <= 1'b0;
    end else begin
      sensing_active <= next_sensing;
      for (int g = 0; g < 3; g++) begin
        group_scale[g*8 +: 8] <= group_enable[g] ? ambient_level : 8'hff;
      end
    end
  end

  // Flag and interrupt; a change in the clearing cycle wins
  logic int_pending;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      zone_change_flag <= 1'b0;
      int_pending <= 1'b0;
      int_n <= 1'b1;
    end else begin
      zone_change_flag <= zone_changed || (zone_change_flag && !status_read);
      int_pending <= (zone_changed && !general_control[ZONE_MASK_BIT]) ||
                     (int_pending && !status_read);
      int_n <= !((zone_changed && !general_control[ZONE_MASK_BIT]) ||
                 (int_pending && !status_read));
    end
  end

  // Checks
  sequence change_s;
    zone_changed;
  endsequence
  sequence read_alone_s;
    status_read && !zone_changed;
  endsequence
  flag_set_a: assert property (@(posedge clk_sys) disable iff (reset)
    change_s |=> zone_change_flag) else $error("zone change did not set flag");
  flag_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
    read_alone_s |=> !zone_change_flag) else $error("status read did not clear flag");
  int_low_a: assert property (@(posedge clk_sys) disable iff (reset)
    change_s ##0 !general_control[ZONE_MASK_BIT] |=> !int_n)
    else $error("unmasked change left interrupt high");
  int_release_a: assert property (@(posedge clk_sys) disable iff (reset)
    read_alone_s |=> int_n) else $error("status read did not release interrupt");
  mask_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
    int_n && general_control[ZONE_MASK_BIT] |=> int_n)
    else $error("masked zone raised interrupt");
  zone_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    !window_done && !start_load |=> $stable(zone))
    else $error("zone moved outside a window end");
  ramp_step_a: assert property (@(posedge clk_sys) disable iff (reset)
    !start_load |=> (ambient_level - $past(ambient_level) <= 8'h01) ||
                    ($past(ambient_level) - ambient_level <= 8'h01))
    else $error("ambient level jumped");
  readback_a: assert property (@(posedge clk_sys) disable iff (reset)
    reg_req.read && reg_req.addr == ADDR_ACTIVE_ZONE_READBACK |=>
    reg_resp.rvalid && reg_resp.rdata == {5'h00, $past(zone)})
    else $error("zone readback wrong");
  zone_range_a: assert property (@(posedge clk_sys) disable iff (reset)
    zone < 3'(ZONE_COUNT)) else $error("zone out of range");
  target_bit_a: assert property (@(posedge clk_sys) disable iff (reset)
    ambient_level >= 8'h80 || $past(reset)) else $error("level below fixed bit");
endmodule
`default_nettype wire

// file: inc/ambient_zone_pkg.sv
// Constants, types and register map of the ambient light zone controller
// Behaviour
// - Four thresholds split light into five zones
// - Start code picks zone target or keeps last
// - Load start zone at sensing start, power-save exit
// - Active zone readable at readback register
// - Zone change sets flag in status register
// - Reading status register clears the flag
// - Zone interrupt mask resets to one
// - Unmasked zone change drives interrupt low
// - Status read releases interrupt high
// - Averaged input compared against 8-bit thresholds
// - LED level ramps stepwise to zone target
// - Averaging window code selects 4 to 512 ms
// - Target bit 7 fixed one, thresholds eight bits
// - Select field picks lower, a, b, higher
// - Any group enable activates sensing, scales group
`default_nettype none
package ambient_zone_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_AMBIENT_CONTROL = 8'h11;
  localparam logic [7:0] ADDR_AMBIENT_START_SELECT = 8'h1b;
  localparam logic [7:0] ADDR_GENERAL_CONTROL = 8'h36;
  localparam logic [7:0] ADDR_STATUS_FLAGS = 8'h3a;
  localparam logic [7:0] ADDR_ACTIVE_ZONE_READBACK = 8'h97;
  localparam logic [7:0] ADDR_ZONE_THRESHOLD_BASE = 8'h70;
  localparam logic [7:0] ADDR_ZONE_TARGET_BASE = 8'h74;
  // Field positions
  localparam int AVG_CODE_LSB = 0;
  localparam int INPUT_SEL_LSB = 3;
  localparam int GROUP_ENABLE_LSB = 5;
  localparam int START_CODE_LSB = 0;
  localparam int ZONE_MASK_BIT = 7;
  localparam int ZONE_CHANGE_BIT = 4;
  localparam int TARGET_FIXED_BIT = 7;
  // Reset values
  localparam logic [7:0] RESET_AMBIENT_CONTROL = 8'h00;
  localparam logic [7:0] RESET_START_SELECT = 8'h00;
  localparam logic [7:0] RESET_GENERAL_CONTROL = 8'h80;
  localparam logic [7:0] RESET_THRESHOLD = 8'h00;
  localparam logic [6:0] RESET_TARGET_DATA = 7'h00;
  // Zone and source encodings
  localparam int ZONE_COUNT = 5;
  localparam int THRESHOLD_COUNT = 4;
  localparam logic [2:0] START_LAST_MIN = 3'h5;
  localparam logic [1:0] SEL_LOWER = 2'h0;
  localparam logic [1:0] SEL_INPUT_A = 2'h1;
  localparam logic [1:0] SEL_INPUT_B = 2'h2;
  localparam logic [1:0] SEL_HIGHER = 2'h3;
  // Timing: one sample per ms, shortest window four samples
  localparam int CLOCK_MHZ = 100;
  localparam int SAMPLE_TIME_US = 1000;
  localparam int SAMPLE_CYCLES = SAMPLE_TIME_US * CLOCK_MHZ;
  localparam int MIN_WINDOW_MS = 4;
  localparam int MIN_WINDOW_LOG2 = 2;
  // Register access request from the serial port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } reg_req_t;
  // Register read answer
  typedef struct packed {
    logic [7:0] rdata;
    logic rvalid;
  } reg_resp_t;
endpackage
`default_nettype wire

// file: testbench/ambient_sensor_model.sv
// Behavioural pair of digitised ambient light sensors
`default_nettype none
module ambient_sensor_model (
  // Light levels asked for by the bench
  input wire logic [7:0] light_a,
  input wire logic [7:0] light_b,
  // Digitised sensor levels towards the block
  output logic [7:0] ambient_input_a,
  output logic [7:0] ambient_input_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // Converter delay keeps changes away from the clock edge, like a real async source
  // Continuous form also carries the starting light level, with no race at time zero
  assign #3 ambient_input_a = light_a;
  assign #3 ambient_input_b = light_b;
endmodule
`default_nettype wire

// file: testbench/test_ambient_light_zone_controller.sv
// Register level tests of the ambient light zone controller
`default_nettype none
module test_ambient_light_zone_controller;
  timeunit 1ns;
  timeprecision 1ns;
  import ambient_zone_pkg::*;
  // Short sample period keeps the longest window near 2000 cycles
  localparam int SP = 4;
  logic clk_sys = 1'b0;
  logic reset;
  reg_req_t reg_req;
  reg_resp_t reg_resp;
  logic [7:0] light_a, light_b, ambient_input_a, ambient_input_b;
  logic power_save;
  logic [7:0] ambient_level;
  logic [23:0] group_scale;
  logic sensing_active, int_n;
  int n_mismatch = 0;
  int checks_done = 0;
  // Ascending thresholds, one sits exactly on a test level
  logic [7:0] thr [4] = '{8'h40, 8'h80, 8'hc0, 8'he0};

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  ambient_sensor_model u_sensor (.light_a(light_a), .light_b(light_b),
    .ambient_input_a(ambient_input_a), .ambient_input_b(ambient_input_b));

  ambient_light_zone_controller #(.SAMPLE_PERIOD(SP)) u_dut (.clk_sys(clk_sys),
    .reset(reset), .reg_req(reg_req), .reg_resp(reg_resp),
    .ambient_input_a(ambient_input_a), .ambient_input_b(ambient_input_b),
    .power_save(power_save), .ambient_level(ambient_level),
    .group_scale(group_scale), .sensing_active(sensing_active), .int_n(int_n));

  // Readback value of a zone target: written data plus fixed top bit
  function automatic logic [7:0] tgt(input int z);
    return 8'h90 + 8'(z * 8);
  endfunction

  // Reference zone: number of thresholds at or below the level
  function automatic logic [7:0] zone_of(input logic [7:0] lvl);
    logic [7:0] z;
    z = 8'h00;
    foreach (thr[i]) if (thr[i] <= lvl) z++;
    return z;
  endfunction

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask

  // One-cycle read strobe, data taken with rvalid
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge clk_sys);
    reg_req <= '0;
    #1;
    while (reg_resp.rvalid !== 1'b1 && n < 3) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check("rvalid", 24'h1, 24'(reg_resp.rvalid));
    d = reg_resp.rdata;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(what, 24'(exp), 24'(d));
  endtask

  // Cycles until the interrupt pin falls, bounded
  task automatic wait_int_low(output int cnt);
    cnt = 0;
    while (int_n !== 1'b0 && cnt < 2200) begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [7:0] d;
    int cnt, win;
    reset = 1'b1;
    reg_req = '0;
    light_a = 8'h10;
    light_b = 8'hd0;
    power_save = 1'b0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("int_n idle", 24'h1, 24'(int_n));
    rd_chk("control", ADDR_AMBIENT_CONTROL, 8'h00);
    rd_chk("start", ADDR_AMBIENT_START_SELECT, 8'h00);
    rd_chk("mask", ADDR_GENERAL_CONTROL, 8'h80);
    rd_chk("unmapped", 8'hff, 8'h00);
    $display("test reset done");
    // Registers, fixed bit, ignored writes
    for (int i = 0; i < 4; i++) wr(ADDR_ZONE_THRESHOLD_BASE + 8'(i), thr[i]);
    for (int i = 0; i < 5; i++) wr(ADDR_ZONE_TARGET_BASE + 8'(i), 8'h10 + 8'(i * 8));
    for (int i = 0; i < 4; i++) rd_chk("thr", ADDR_ZONE_THRESHOLD_BASE + 8'(i), thr[i]);
    for (int i = 0; i < 5; i++) rd_chk("tgt", ADDR_ZONE_TARGET_BASE + 8'(i), tgt(i));
    wr(ADDR_ACTIVE_ZONE_READBACK, 8'h07);
    rd_chk("zone ro", ADDR_ACTIVE_ZONE_READBACK, 8'h00);
    wr(ADDR_STATUS_FLAGS, 8'hff);
    rd_chk("status ro", ADDR_STATUS_FLAGS, 8'h00);
    $display("test registers done");
    // Start in zone 4, light says zone 0, interrupt unmasked
    wr(ADDR_GENERAL_CONTROL, 8'h00);
    wr(ADDR_AMBIENT_START_SELECT, 8'h04);
    wr(ADDR_AMBIENT_CONTROL, 8'h28);
    repeat (3) @(posedge clk_sys);
    #1;
    check("active", 24'h1, 24'(sensing_active));
    check("scale", 24'hffff, 24'(group_scale[23:8]));
    check("scale g0", 24'(tgt(4)), 24'(group_scale[7:0]));
    check("start level", 24'(tgt(4)), 24'(ambient_level));
    check("no int on start", 24'h1, 24'(int_n));
    wait_int_low(cnt);
    check("int_n low", 24'h0, 24'(int_n));
    cnt = 0;
    while (ambient_level !== tgt(0) && cnt < 1000) begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end
    // Thirty-two single steps, one per sample tick
    check("ramp gradual", 24'h1, 24'(cnt >= 31 * SP - 8));
    check("ramp end", 24'(tgt(0)), 24'(ambient_level));
    rd_chk("zone 0", ADDR_ACTIVE_ZONE_READBACK, 8'h00);
    rd_chk("flag set", ADDR_STATUS_FLAGS, 8'h10);
    check("int_n released", 24'h1, 24'(int_n));
    rd_chk("flag clear", ADDR_STATUS_FLAGS, 8'h00);
    $display("test zone change done");
    // Every source select; level b on a threshold exactly
    light_a <= 8'hd0;
    light_b <= 8'h80;
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_AMBIENT_CONTROL, {3'b001, 2'(s), 3'b000});
      repeat (150) @(posedge clk_sys);
      rd_chk("zone by select", ADDR_ACTIVE_ZONE_READBACK, (s % 2) ? 8'h03 : 8'h02);
      rd(ADDR_STATUS_FLAGS, d);
    end
    $display("test select done");
    // Start codes 0 to 4 on each power-save exit
    for (int n = 0; n < 5; n++) begin
      @(posedge clk_sys);
      power_save <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      check("idle in save", 24'h0, 24'(sensing_active));
      wr(ADDR_AMBIENT_START_SELECT, 8'(n));
      @(posedge clk_sys);
      power_save <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      check("resume level", 24'(tgt(n)), 24'(ambient_level));
      rd_chk("resume zone", ADDR_ACTIVE_ZONE_READBACK, 8'(n));
    end
    $display("test start codes done");
    // Every averaging code, window restarted by power-save exit
    wr(ADDR_AMBIENT_START_SELECT, 8'h05);
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_sys);
      power_save <= 1'b1;
      light_a <= (c % 2) ? 8'hd0 : 8'h10;
      wr(ADDR_AMBIENT_CONTROL, {3'b001, 2'b01, 3'(c)});
      repeat (4) @(posedge clk_sys);
      rd(ADDR_STATUS_FLAGS, d);
      @(posedge clk_sys);
      power_save <= 1'b0;
      wait_int_low(cnt);
      win = (4 << c) * SP;
      check("window", 24'h1, 24'(cnt >= win - 8 && cnt <= win + 16));
      rd_chk("zone avg", ADDR_ACTIVE_ZONE_READBACK, zone_of(light_a));
      rd(ADDR_STATUS_FLAGS, d);
    end
    $display("test averaging done");
    wr(ADDR_AMBIENT_CONTROL, 8'h00);
    repeat (3) @(posedge clk_sys);
    #1;
    check("no groups", 24'h0, 24'(sensing_active));
    $display("test disable done");
    conclude();
  end

  // Watchdog well past the expected run of about 5200 cycles
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
